//--- design/sdma_core.sv
`timescale 1ns/10ps
module sdma_core
    import sdma_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   acc_valid,
    input  wire sdma_pkg::sdma_mode_t   acc_mode,
    input  wire sdma_pkg::sdma_op_t     acc_op,
    input  wire logic [10:0]            acc_addr,
    input  wire logic [2:0]             acc_bit,
    input  wire logic [7:0]             acc_wdata,
    output logic      [7:0]             acc_rdata,
    output logic                        acc_rvalid,
    output logic      [7:0]             sfr_addr,
    output logic                        sfr_wr,
    output logic                        sfr_rd,
    output logic      [7:0]             sfr_wdata,
    input  wire logic [7:0]             sfr_rdata,
    input  wire logic                   sfr_hit,
    input  wire logic                   sfr_ro
);
    import sdma_pkg::*;

    // The remaining special registers live outside; sfr_hit says an offset is mapped and
    // sfr_ro says it is read-only, so unmapped offsets and protected registers are handled here.
    logic [7:0]  ptr_a, ptr_bl, ptr_bh, ptr_cl, ptr_ch;
    logic [7:0]  next_ptr_a, next_ptr_bl, next_ptr_bh, next_ptr_cl, next_ptr_ch;
    logic [7:0]  next_rdata;
    logic        next_rvalid;
    logic [7:0]  next_sfr_addr, next_sfr_wdata;
    logic        next_sfr_wr, next_sfr_rd;
    logic [10:0] dir_addr, eff_addr;
    logic [7:0]  eff_sect, eff_off, cur_byte, mod_byte, ram_rd;
    logic        ram_we, own_reg;

    // The RAM holds general storage only; sector and the low seven offset bits index it.
    // It is not reset, so software must write a location before it reads it.
    sdma_gp_ram u_ram (
        .sys_clk (sys_clk),
        .wr_en   (ram_we),
        .wr_addr ({eff_addr[10:8], eff_off[6:0]}),
        .wr_data (mod_byte),
        .rd_addr ({eff_addr[10:8], eff_off[6:0]}),
        .rd_data (ram_rd)
    );

    always_comb begin
        if (acc_mode == SDMA_MODE_EXT) begin
            dir_addr = acc_addr;
        end else begin
            dir_addr = {3'b000, acc_addr[7:0]};
        end
        // Indirect port offsets redirect through their pointers; no bank register exists.
        // Sector bits beyond the three decoded are ignored for pointers b and c.
        if (dir_addr == {3'b000, SDMA_OFF_PORT_A}) begin
            eff_addr = {3'b000, ptr_a};
        end else if (dir_addr == {3'b000, SDMA_OFF_PORT_B}) begin
            eff_addr = {ptr_bh[2:0], ptr_bl};
        end else if (dir_addr == {3'b000, SDMA_OFF_PORT_C}) begin
            eff_addr = {ptr_ch[2:0], ptr_cl};
        end else begin
            eff_addr = dir_addr;
        end
        eff_sect  = {5'h00, eff_addr[10:8]};
        eff_off   = eff_addr[7:0];
    end

    always_comb begin
        // The own_reg flag marks pointers and ports, which live here rather than outside.
        cur_byte = ram_rd;
        own_reg  = 1'b0;
        if (eff_sect == 8'h00 && !eff_off[SDMA_GP_BIT]) begin
            own_reg = 1'b1;
            if (eff_off == SDMA_OFF_PTR_A) begin
                cur_byte = ptr_a;
            end else if (eff_off == SDMA_OFF_PTR_BL) begin
                cur_byte = ptr_bl;
            end else if (eff_off == SDMA_OFF_PTR_BH) begin
                cur_byte = ptr_bh;
            end else if (eff_off == SDMA_OFF_PTR_CL) begin
                cur_byte = ptr_cl;
            end else if (eff_off == SDMA_OFF_PTR_CH) begin
                cur_byte = ptr_ch;
            end else if (eff_off == SDMA_OFF_PORT_A || eff_off == SDMA_OFF_PORT_B
                         || eff_off == SDMA_OFF_PORT_C) begin
                cur_byte = SDMA_ZERO_BYTE;
            end else begin
                own_reg  = 1'b0;
                cur_byte = sfr_hit ? sfr_rdata : SDMA_ZERO_BYTE;
            end
        end else if (!eff_off[SDMA_GP_BIT]) begin
            cur_byte = sfr_hit ? sfr_rdata : SDMA_ZERO_BYTE;
        end
        // Bit operations on outside registers also leave through sfr_wdata, so the
        // read-modify-write is done once here instead of in every register.
        case (acc_op)
            SDMA_OP_BSET: mod_byte = cur_byte | (8'h01 << acc_bit);
            SDMA_OP_BCLR: mod_byte = cur_byte & ~(8'h01 << acc_bit);
            default:      mod_byte = acc_wdata;
        endcase
        ram_we = acc_valid && acc_op != SDMA_OP_READ && eff_off[SDMA_GP_BIT];
    end

    always_comb begin
        next_ptr_a     = ptr_a;
        next_ptr_bl    = ptr_bl;
        next_ptr_bh    = ptr_bh;
        next_ptr_cl    = ptr_cl;
        next_ptr_ch    = ptr_ch;
        next_rvalid    = acc_valid && acc_op == SDMA_OP_READ;
        // Read data keeps its last value until the next read.
        next_rdata     = (acc_valid && acc_op == SDMA_OP_READ) ? cur_byte : acc_rdata;
        next_sfr_addr  = eff_off;
        next_sfr_wdata = mod_byte;
        next_sfr_wr    = 1'b0;
        next_sfr_rd    = 1'b0;
        // Outside strobes are registered, so an outside write lands one edge after its request.
        // A read of the same register on the very next cycle still sees the old value;
        // the trade keeps every output of this block straight from a flip-flop.
        if (acc_valid && !eff_off[SDMA_GP_BIT] && !own_reg) begin
            next_sfr_rd = acc_op == SDMA_OP_READ;
            next_sfr_wr = acc_op != SDMA_OP_READ && sfr_hit && !sfr_ro;
        end
        if (acc_valid && acc_op != SDMA_OP_READ && own_reg) begin
            if (eff_off == SDMA_OFF_PTR_A) begin
                next_ptr_a = mod_byte;
            end else if (eff_off == SDMA_OFF_PTR_BL) begin
                next_ptr_bl = mod_byte;
            end else if (eff_off == SDMA_OFF_PTR_BH) begin
                next_ptr_bh = mod_byte;
            end else if (eff_off == SDMA_OFF_PTR_CL) begin
                next_ptr_cl = mod_byte;
            end else if (eff_off == SDMA_OFF_PTR_CH) begin
                next_ptr_ch = mod_byte;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // Pointers get a defined value so that indirect access is never unknown.
            ptr_a      <= SDMA_PTR_RESET;
            ptr_bl     <= SDMA_PTR_RESET;
            ptr_bh     <= SDMA_PTR_RESET;
            ptr_cl     <= SDMA_PTR_RESET;
            ptr_ch     <= SDMA_PTR_RESET;
            acc_rdata  <= SDMA_ZERO_BYTE;
            acc_rvalid <= 1'b0;
            sfr_addr   <= SDMA_ZERO_BYTE;
            sfr_wdata  <= SDMA_ZERO_BYTE;
            sfr_wr     <= 1'b0;
            sfr_rd     <= 1'b0;
        end else begin
            ptr_a      <= next_ptr_a;
            ptr_bl     <= next_ptr_bl;
            ptr_bh     <= next_ptr_bh;
            ptr_cl     <= next_ptr_cl;
            ptr_ch     <= next_ptr_ch;
            acc_rdata  <= next_rdata;
            acc_rvalid <= next_rvalid;
            sfr_addr   <= next_sfr_addr;
            sfr_wdata  <= next_sfr_wdata;
            sfr_wr     <= next_sfr_wr;
            sfr_rd     <= next_sfr_rd;
        end
    end

    // These checks watch the decode as well as the registered answers, so a fault in
    // either the address path or the read-modify-write shows up at the cycle it happens.
    // Outside registers are judged only through sfr_hit and sfr_ro, not their contents.
    gp_write_lands_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op == SDMA_OP_WRITE && eff_off[7] ##1 acc_valid && acc_op == SDMA_OP_READ
        && $past(eff_addr) == eff_addr |=> acc_rdata == $past(acc_wdata, 2))
        else $error("General storage write not read back.");
    special_zero_read_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op == SDMA_OP_READ && !eff_off[7] && !own_reg && !sfr_hit
        |=> acc_rvalid && acc_rdata == 8'h00)
        else $error("Unmapped special offset did not read zero.");
    ro_untouched_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op != SDMA_OP_READ && sfr_ro |=> !sfr_wr)
        else $error("Write reached a read-only register.");
    port_a_sector_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_mode == SDMA_MODE_STD && acc_addr[7:0] == 8'h00 |-> eff_addr == {3'b000, ptr_a})
        else $error("Port a left sector zero.");
    port_b_target_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_mode == SDMA_MODE_STD && acc_addr[7:0] == 8'h02 |-> eff_addr == {ptr_bh[2:0], ptr_bl})
        else $error("Port b target wrong.");
    std_sector0_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_mode == SDMA_MODE_STD && acc_addr[7:0] > 8'h0E |-> eff_addr[10:8] == 3'b000)
        else $error("Standard access left sector zero.");
    ext_addr_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_mode == SDMA_MODE_EXT && acc_addr[10:8] != 3'b000 |-> eff_addr == acc_addr)
        else $error("Extended address not honoured.");
    port_self_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op == SDMA_OP_READ && eff_sect == 8'h00
        && (eff_off == SDMA_OFF_PORT_A || eff_off == SDMA_OFF_PORT_B || eff_off == SDMA_OFF_PORT_C)
        |=> acc_rvalid && acc_rdata == SDMA_ZERO_BYTE)
        else $error("Indirect port read as itself not zero.");
    bit_set_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op == SDMA_OP_BSET |-> mod_byte[acc_bit])
        else $error("Bit set lost.");
    ptr_load_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op == SDMA_OP_WRITE && eff_sect == 8'h00 && eff_off == SDMA_OFF_PTR_BH
        |=> ptr_bh == $past(acc_wdata))
        else $error("Pointer b sector byte not loaded.");
    port_write_none_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op != SDMA_OP_READ && own_reg && (eff_off == SDMA_OFF_PORT_A
        || eff_off == SDMA_OFF_PORT_B || eff_off == SDMA_OFF_PORT_C) |-> !ram_we ##1 !sfr_wr
        && $stable(ptr_a) && $stable(ptr_bl) && $stable(ptr_bh) && $stable(ptr_cl) && $stable(ptr_ch))
        else $error("Write to an indirect port as itself changed state.");
    gp_no_sfr_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && eff_off[SDMA_GP_BIT] |=> !sfr_wr && !sfr_rd)
        else $error("General storage access reached the outside registers.");
    sfr_read_strobe_a: assert property (@(posedge sys_clk) disable iff (reset)
        acc_valid && acc_op == SDMA_OP_READ && !eff_off[SDMA_GP_BIT] && !own_reg
        |=> sfr_rd && acc_rvalid && sfr_addr == $past(eff_off))
        else $error("Outside register read not strobed.");
    rdata_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        !(acc_valid && acc_op == SDMA_OP_READ) |=> !acc_rvalid && $stable(acc_rdata))
        else $error("Read data changed without a read.");

    cov_ext_c: cover property (@(posedge sys_clk) acc_valid && acc_mode == SDMA_MODE_EXT && acc_addr[10:8] == 3'h7);
    cov_ind_c: cover property (@(posedge sys_clk) acc_valid && acc_addr[7:0] == 8'h0C && ptr_ch[2:0] == 3'h7);
    cov_clr_c: cover property (@(posedge sys_clk) acc_valid && acc_op == SDMA_OP_BCLR && eff_off[7]);
    cov_b2b_c: cover property (@(posedge sys_clk)
        acc_valid && acc_op == SDMA_OP_WRITE ##1 acc_valid && acc_op == SDMA_OP_READ);
    cov_sfr_ind_c: cover property (@(posedge sys_clk)
        acc_valid && acc_addr[7:0] == 8'h00 && !eff_off[SDMA_GP_BIT] && !own_reg);
endmodule : sdma_core

//--- design/sdma_pkg.sv
// Summary of operation
// - Data memory is byte-wide RAM; every location holds one byte.
// - Offsets 00H-7FH are special registers, 80H-FFH general storage, in each sector.
// - General storage reads and writes freely, with single-bit set and clear.
// - Special registers sit at fixed offsets; empty special locations read 00H.
// - Read-only special registers ignore instruction writes; most others are read-write.
// - No bank pointer; sector comes from pointer registers or extended address only.
// - Pointer pairs b and c: high byte picks sector, low byte picks offset.
// - Extended instructions carry an 11-bit address: sector high, location low.
// - Standard direct addressing reaches sector 0 only.
// - Indirect port accesses act on the location named by its paired pointer.
// - Port a uses pointer_a, sector 0 only; ports b and c reach any sector.
// - Reading an indirect port as itself gives 00H; writing it does nothing.
package sdma_pkg;
    localparam int          SDMA_DATA_W      = 8;
    localparam int          SDMA_ADDR_W      = 11;
    localparam int          SDMA_SECT_W      = 3;
    localparam int          SDMA_RAM_DEPTH   = 1024;
    localparam logic [7:0]  SDMA_OFF_PORT_A  = 8'h00;
    localparam logic [7:0]  SDMA_OFF_PTR_A   = 8'h01;
    localparam logic [7:0]  SDMA_OFF_PORT_B  = 8'h02;
    localparam logic [7:0]  SDMA_OFF_PTR_BL  = 8'h03;
    localparam logic [7:0]  SDMA_OFF_PTR_BH  = 8'h04;
    localparam logic [7:0]  SDMA_OFF_PORT_C  = 8'h0C;
    localparam logic [7:0]  SDMA_OFF_PTR_CL  = 8'h0D;
    localparam logic [7:0]  SDMA_OFF_PTR_CH  = 8'h0E;
    localparam logic [7:0]  SDMA_ZERO_BYTE   = 8'h00;
    localparam logic [7:0]  SDMA_PTR_RESET   = 8'h00;
    localparam int          SDMA_GP_BIT      = 7;

    typedef enum logic [1:0] {
        SDMA_OP_WRITE = 2'b00,
        SDMA_OP_BSET  = 2'b01,
        SDMA_OP_BCLR  = 2'b10,
        SDMA_OP_READ  = 2'b11
    } sdma_op_t;

    typedef enum logic [1:0] {
        SDMA_MODE_STD  = 2'b00,
        SDMA_MODE_EXT  = 2'b01
    } sdma_mode_t;
endpackage : sdma_pkg

//--- design/sdma_gp_ram.sv
`timescale 1ns/10ps
module sdma_gp_ram
    import sdma_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   wr_en,
    input  wire logic [9:0]             wr_addr,
    input  wire logic [SDMA_DATA_W-1:0] wr_data,
    input  wire logic [9:0]             rd_addr,
    output logic      [SDMA_DATA_W-1:0] rd_data
);
    // Asynchronous read lets a bit set or clear finish in one cycle as read-modify-write.
    logic [SDMA_DATA_W-1:0] mem [0:SDMA_RAM_DEPTH-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_comb begin
        rd_data = mem[rd_addr];
    end
endmodule : sdma_gp_ram

//--- verif/sdma_sfr_model.sv
`timescale 1ns/10ps
module sdma_sfr_model
    import sdma_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] look_off,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_hit,
    output logic            sfr_ro,
    output int              ro_writes
);
    localparam logic [7:0] RW_OFF = 8'h05;
    localparam logic [7:0] RO_OFF = 8'h0A;
    localparam logic [7:0] RO_VAL = 8'hC3;
    logic [7:0] rw_reg = 8'h00;
    initial ro_writes = 0;
    // Unmapped offsets return a pattern, so the core itself must supply the zero byte.
    always_comb begin
        sfr_hit   = (look_off == RW_OFF) || (look_off == RO_OFF);
        sfr_ro    = (look_off == RO_OFF);
        sfr_rdata = (look_off == RW_OFF) ? rw_reg : ((look_off == RO_OFF) ? RO_VAL : 8'h5A);
    end
    always @(posedge sys_clk) begin
        if (sfr_wr && sfr_addr == RW_OFF) rw_reg <= sfr_wdata;
        if (sfr_wr && sfr_addr == RO_OFF) ro_writes <= ro_writes + 1;
    end
endmodule : sdma_sfr_model

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import sdma_pkg::*;
    typedef struct {sdma_mode_t m; sdma_op_t o; logic [10:0] a; logic [2:0] b; logic [7:0] d;} sdma_row_t;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic       acc_valid = 1'b0;
    sdma_mode_t acc_mode = SDMA_MODE_STD;
    sdma_op_t   acc_op = SDMA_OP_READ;
    logic [10:0] acc_addr = 11'h000;
    logic [2:0] acc_bit = 3'h0;
    logic [7:0] acc_wdata = 8'h00;
    logic [7:0] acc_rdata, sfr_addr, sfr_wdata, sfr_rdata, q;
    logic       acc_rvalid, sfr_wr, sfr_rd, sfr_hit, sfr_ro;
    int         ro_writes;
    int         n_errors = 0;
    int         n_checks = 0;
    sdma_row_t  rows[$];

    initial forever #2 sys_clk = ~sys_clk;

    sdma_core DUT (.sys_clk(sys_clk), .reset(reset), .acc_valid(acc_valid), .acc_mode(acc_mode),
        .acc_op(acc_op), .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sfr_ro(sfr_ro));
    // The outside bank answers for the effective offset, so indirect access reaches it too.
    sdma_sfr_model sfr_bank (.sys_clk(sys_clk), .look_off(DUT.eff_off), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .sfr_ro(sfr_ro), .ro_writes(ro_writes));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic access(input sdma_row_t r, output logic [7:0] rd);
        @(negedge sys_clk);
        acc_valid = 1'b1;
        acc_mode = r.m;
        acc_op = r.o;
        acc_addr = r.a;
        acc_bit = r.b;
        acc_wdata = r.d;
        @(negedge sys_clk);
        acc_valid = 1'b0;
        rd = (acc_rvalid === 1'b1) ? acc_rdata : 8'hXX;
    endtask : access

    task automatic add(input sdma_mode_t m, input sdma_op_t o, input logic [10:0] a, input logic [2:0] b,
                       input logic [7:0] d);
        rows.push_back('{m, o, a, b, d});
    endtask : add

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    initial begin
        repeat (2000) @(posedge sys_clk);
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        final_report();
    end

    initial begin
        add(SDMA_MODE_EXT, SDMA_OP_WRITE, 11'h1F0, 3'h0, 8'h3C);
        add(SDMA_MODE_EXT, SDMA_OP_READ, 11'h1F0, 3'h0, 8'h3C);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h0F0, 3'h0, 8'h11);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h1F0, 3'h0, 8'h11);
        add(SDMA_MODE_EXT, SDMA_OP_READ, 11'h1F0, 3'h0, 8'h3C);
        add(SDMA_MODE_STD, SDMA_OP_BSET, 11'h0F0, 3'h7, 8'h00);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h0F0, 3'h0, 8'h91);
        add(SDMA_MODE_EXT, SDMA_OP_BCLR, 11'h0F0, 3'h0, 8'h00);
        add(SDMA_MODE_EXT, SDMA_OP_READ, 11'h0F0, 3'h0, 8'h90);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h01F, 3'h0, 8'h00);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h005, 3'h0, 8'h77);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h005, 3'h0, 8'h77);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h00A, 3'h0, 8'h55);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h00A, 3'h0, 8'hC3);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h003, 3'h0, 8'hF0);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h004, 3'h0, 8'h01);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h002, 3'h0, 8'h3C);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h002, 3'h0, 8'h66);
        add(SDMA_MODE_EXT, SDMA_OP_READ, 11'h1F0, 3'h0, 8'h66);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h001, 3'h0, 8'hF0);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h000, 3'h0, 8'h90);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h00D, 3'h0, 8'h80);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h00E, 3'h0, 8'h07);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h00C, 3'h0, 8'hE7);
        add(SDMA_MODE_EXT, SDMA_OP_READ, 11'h780, 3'h0, 8'hE7);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h00E, 3'h0, 8'h07);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h001, 3'h0, 8'h00);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h000, 3'h0, 8'h00);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h001, 3'h0, 8'h02);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h000, 3'h0, 8'h5A);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h000, 3'h0, 8'h00);
        add(SDMA_MODE_EXT, SDMA_OP_READ, 11'h1F0, 3'h0, 8'h66);
        add(SDMA_MODE_STD, SDMA_OP_WRITE, 11'h001, 3'h0, 8'h05);
        add(SDMA_MODE_STD, SDMA_OP_READ, 11'h000, 3'h0, 8'h77);
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        foreach (rows[i]) begin
            access(rows[i], q);
            if (rows[i].o == SDMA_OP_READ) check(q, rows[i].d);
        end
        $display("table test done");
        // A general storage read issued on the very next cycle after a write must already see that write.
        @(negedge sys_clk);
        acc_valid = 1'b1;
        acc_mode = SDMA_MODE_EXT;
        acc_op = SDMA_OP_WRITE;
        acc_addr = 11'h2A5;
        acc_wdata = 8'h4E;
        @(negedge sys_clk);
        acc_op = SDMA_OP_READ;
        @(negedge sys_clk);
        acc_valid = 1'b0;
        check((acc_rvalid === 1'b1) ? acc_rdata : 8'hXX, 8'h4E);
        check(8'(ro_writes), 8'h00);
        access('{SDMA_MODE_STD, SDMA_OP_READ, 11'h005, 3'h0, 8'h00}, q);
        check(q, 8'h77);
        check({7'h00, sfr_rd}, 8'h01);
        check(sfr_addr, 8'h05);
        $display("back to back test done");
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        access('{SDMA_MODE_STD, SDMA_OP_READ, 11'h004, 3'h0, 8'h00}, q);
        check(q, SDMA_PTR_RESET);
        access('{SDMA_MODE_STD, SDMA_OP_READ, 11'h002, 3'h0, 8'h00}, q);
        check(q, SDMA_ZERO_BYTE);
        $display("reset test done");
        final_report();
    end
endmodule : tb_top
